// file: verilog/csc_pkg.sv
// csc_pkg: constants and types for the continuity scan controller.
// assumes: a 32-bit APB slave with an 8-bit byte address.
package csc_pkg;
  localparam int EP_N = 203;
  localparam int LT_N = 7;
  localparam int XT_N = 2;
  localparam int T_N = 9;
  localparam int GRP_N = 5;
  localparam int IRQ_WORDS = 7;
  localparam logic [2:0] MISS_LOSS = 3'h7;
  localparam logic [2:0] TMR_NONE = 3'h7;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DIV = 8'h04;
  localparam logic [7:0] A_FORCE = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_XCFG = 8'h10;
  localparam logic [7:0] A_IRQ = 8'h14;
  localparam logic [7:0] A_SUMM = 8'h18;
  localparam logic [7:0] A_EPSEL = 8'h1C;
  localparam logic [7:0] A_EPCFG = 8'h20;
  localparam logic [7:0] A_EPSTAT = 8'h24;
  localparam logic [7:0] A_LPER = 8'h40;
  localparam logic [7:0] A_XPER = 8'h60;
  localparam int CTRL_EN_B = 0;
  localparam int CTRL_IRQEN_B = 1;
  localparam int STAT_BEGUN_B = 16;
  localparam int STAT_DONE_B = 17;
  localparam int STAT_OVR_B = 18;
  localparam int XCFG_GSEL_LSB = 4;
  localparam int EPCFG_SLOT_LSB = 4;
  localparam int EPCFG_GEN_LSB = 8;
  localparam int EPCFG_ONESHOT_B = 16;
  localparam int EPSTAT_LOSS_B = 4;
  localparam int EPSTAT_EXT_LSB = 8;
  localparam logic [15:0] DIV_RST = 16'h0100;
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_SWEEP = 2'b10
  } csc_state_t;
endpackage : csc_pkg

// file: verilog/csc_top.sv
// csc_top: base tick divider, nine sweep timers, endpoint sweep, irq tree.
// assumes: APB master on pclk; frame pipeline strobes on pclk.
// Functional notes
// - expiry sweeps all 203 endpoints' miss counters
// - one endpoint per cycle; lookups stall one
// - enable low keeps timers from counting
// - divider ticks every programmed cycle count
// - seven loss timers expire at own period
// - seven missed sweeps raise loss indication
// - force mask starts sweeps for marked timers
// - disable aborts sweep, zeroes timers, keeps misses
// - active mask shows timers served by sweep
// - sticky flags for sweep begun and done
// - re-expiry before sweep done flags overrun
// - two extract timers share ticks and sweep
// - hidden 3-bit slot counter per extract timer
// - forced extract sweep uses programmed slot
// - five groups each select an extract timer
// - group updates need slot, timer, enable match
// - groups one to four set extract bits
// - group five copies its enable value
// - periodic extraction is always single shot
// - irq when irq enable and endpoint irq
// - summary bit n ORs irq word n
// - sweep increments miss; valid frame clears it
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module csc_top
  import csc_pkg::*;
#(
  parameter int TW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_lookup,
  input wire logic frame_ccm_ok,
  input wire logic [7:0] frame_ep_idx,
  input wire logic [EP_N-1:0] ep_irq,
  output logic [EP_N-1:0] loss_vec,
  output logic irq
);
  typedef struct packed {
    csc_state_t st;
    logic ctrl_en;
    logic irq_en;
    logic [TW-1:0] div;
    logic [LT_N-1:0][TW-1:0] lper;
    logic [XT_N-1:0][TW-1:0] xper;
    logic [2:0] fslot;
    logic [GRP_N-1:0] gsel;
    logic [7:0] epsel;
    logic [T_N-1:0] act;
    logic [T_N-1:0] pend;
    logic begun;
    logic done;
    logic ovr;
    logic [XT_N-1:0][2:0] pslot;
    logic [XT_N-1:0][2:0] aslot;
    logic [XT_N-1:0][2:0] scnt;
    logic [TW-1:0] divc;
    logic [T_N-1:0][TW-1:0] tmr;
    logic [7:0] idx;
    logic [EP_N-1:0][16:0] ep_cfg;
    logic [EP_N-1:0][2:0] miss;
    logic [EP_N-1:0] loss;
    logic [EP_N-1:0][GRP_N-1:0] ext;
    logic irq;
    logic [IRQ_WORDS-1:0] summ;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } csc_st_t;

  csc_st_t s;
  csc_st_t n;
  logic acc;
  logic wr;
  logic stall;
  logic tick;
  logic [T_N-1:0] expd;
  logic [T_N-1:0] force_m;
  logic [T_N-1:0] fire;

  always_comb
  begin
    logic [31:0] rd;
    logic hit;
    logic [TW-1:0] per;
    logic [2:0] tsel;
    logic [2:0] eslot;
    logic [GRP_N-1:0] gen;
    logic [IRQ_WORDS*32-1:0] irqpad;
    int k;
    rd = '0;
    hit = 1'b1;
    per = '0;
    tsel = '0;
    eslot = '0;
    gen = '0;
    irqpad = '0;
    k = 0;
    n = s;
    tick = 1'b0;
    expd = '0;
    fire = '0;
    acc = psel && penable && s.pready;
    wr = acc && pwrite;
    stall = frame_lookup || acc;
    force_m = '0;
    // register read decode
    if (paddr == A_CTRL)
    begin
      rd[CTRL_EN_B] = s.ctrl_en;
      rd[CTRL_IRQEN_B] = s.irq_en;
    end
    else if (paddr == A_DIV)
      rd[TW-1:0] = s.div;
    else if (paddr == A_FORCE)
      rd = '0;
    else if (paddr == A_STAT)
    begin
      rd[T_N-1:0] = s.act;
      rd[STAT_BEGUN_B] = s.begun;
      rd[STAT_DONE_B] = s.done;
      rd[STAT_OVR_B] = s.ovr;
    end
    else if (paddr == A_XCFG)
    begin
      rd[2:0] = s.fslot;
      rd[XCFG_GSEL_LSB +: GRP_N] = s.gsel;
    end
    else if (paddr == A_IRQ)
      rd[0] = |ep_irq;
    else if (paddr == A_SUMM)
      rd[IRQ_WORDS-1:0] = s.summ;
    else if (paddr == A_EPSEL)
      rd[7:0] = s.epsel;
    else if (paddr == A_EPCFG)
    begin
      if (s.epsel < 8'(EP_N))
        rd[16:0] = s.ep_cfg[s.epsel];
    end
    else if (paddr == A_EPSTAT)
    begin
      if (s.epsel < 8'(EP_N))
      begin
        rd[2:0] = s.miss[s.epsel];
        rd[EPSTAT_LOSS_B] = s.loss[s.epsel];
        rd[EPSTAT_EXT_LSB +: GRP_N] = s.ext[s.epsel];
      end
    end
    else
    begin
      hit = 1'b0;
      for (int j = 0; j < LT_N; j++)
      begin
        if (paddr == 8'(A_LPER + 4 * j))
        begin
          hit = 1'b1;
          rd[TW-1:0] = s.lper[j];
        end
      end
      for (int j = 0; j < XT_N; j++)
      begin
        if (paddr == 8'(A_XPER + 4 * j))
        begin
          hit = 1'b1;
          rd[TW-1:0] = s.xper[j];
        end
      end
    end
    // apb: no wait state, answer taken in the access phase
    n.pready = psel && !penable;
    n.pslverr = 1'b0;
    if (psel && !penable)
    begin
      n.prdata = pwrite ? 32'h0000_0000 : rd;
      n.pslverr = !hit;
    end
    // register writes; hardware sets below win over clears
    if (wr && hit)
    begin
      if (paddr == A_CTRL)
      begin
        n.ctrl_en = pwdata[CTRL_EN_B];
        n.irq_en = pwdata[CTRL_IRQEN_B];
      end
      else if (paddr == A_DIV)
        n.div = pwdata[TW-1:0];
      else if (paddr == A_FORCE)
        force_m = pwdata[T_N-1:0];
      else if (paddr == A_STAT)
      begin
        n.begun = s.begun && !pwdata[STAT_BEGUN_B];
        n.done = s.done && !pwdata[STAT_DONE_B];
        n.ovr = s.ovr && !pwdata[STAT_OVR_B];
      end
      else if (paddr == A_XCFG)
      begin
        n.fslot = pwdata[2:0];
        n.gsel = pwdata[XCFG_GSEL_LSB +: GRP_N];
      end
      else if (paddr == A_EPSEL)
        n.epsel = pwdata[7:0];
      else if (paddr == A_EPCFG)
      begin
        if (s.epsel < 8'(EP_N))
          n.ep_cfg[s.epsel] = pwdata[16:0];
      end
      else
      begin
        for (int j = 0; j < LT_N; j++)
          if (paddr == 8'(A_LPER + 4 * j))
            n.lper[j] = pwdata[TW-1:0];
        for (int j = 0; j < XT_N; j++)
          if (paddr == 8'(A_XPER + 4 * j))
            n.xper[j] = pwdata[TW-1:0];
      end
    end
    // frame pipeline: valid frame clears misses, extraction is one shot
    if (frame_lookup && frame_ep_idx < 8'(EP_N))
    begin
      if (frame_ccm_ok)
        n.miss[frame_ep_idx] = '0;
      n.ext[frame_ep_idx] = '0;
    end
    if (!s.ctrl_en)
    begin
      n.divc = '0;
      n.tmr = '0;
      n.pend = '0;
      n.act = '0;
      n.idx = '0;
      n.st = S_IDLE;
    end
    else
    begin
      tick = ({1'b0, s.divc} + 17'h00001) >= {1'b0, s.div};
      n.divc = tick ? '0 : s.divc + 16'h0001;
      for (int j = 0; j < T_N; j++)
      begin
        per = (j < LT_N) ? s.lper[j] : s.xper[j-LT_N];
        if (tick && per != '0)
        begin
          if (({1'b0, s.tmr[j]} + 17'h00001) >= {1'b0, per})
          begin
            expd[j] = 1'b1;
            n.tmr[j] = '0;
          end
          else
            n.tmr[j] = s.tmr[j] + 16'h0001;
        end
      end
      fire = expd | force_m;
      if (|(expd & (s.pend | s.act)))
        n.ovr = 1'b1;
      for (int j = 0; j < XT_N; j++)
      begin
        if (expd[LT_N+j])
        begin
          n.pslot[j] = s.scnt[j];
          n.scnt[j] = s.scnt[j] + 3'h1;
        end
        if (force_m[LT_N+j])
          n.pslot[j] = s.fslot;
      end
      n.pend = s.pend | fire;
      case (s.st)
        S_IDLE:
        begin
          if (s.pend != '0)
          begin
            n.act = s.pend;
            n.aslot = s.pslot;
            n.pend = fire;
            n.idx = '0;
            n.begun = 1'b1;
            n.st = S_SWEEP;
          end
        end
        S_SWEEP:
        begin
          if (!stall)
          begin
            tsel = s.ep_cfg[s.idx][2:0];
            eslot = s.ep_cfg[s.idx][EPCFG_SLOT_LSB +: 3];
            gen = s.ep_cfg[s.idx][EPCFG_GEN_LSB +: GRP_N];
            if (tsel != TMR_NONE && s.act[tsel] && s.miss[s.idx] != MISS_LOSS)
              n.miss[s.idx] = s.miss[s.idx] + 3'h1;
            for (int g = 0; g < GRP_N; g++)
            begin
              k = int'(s.gsel[g]);
              if (eslot == s.aslot[k] && s.act[LT_N+k] && gen[g])
              begin
                if (g < GRP_N - 1)
                  n.ext[s.idx][g] = 1'b1;
                else
                  n.ext[s.idx][g] = gen[g];
              end
            end
            if (s.idx == 8'(EP_N - 1))
            begin
              n.st = S_IDLE;
              n.act = '0;
              n.done = 1'b1;
            end
            else
              n.idx = s.idx + 8'h01;
          end
        end
        default:
          n.st = S_IDLE;
      endcase
    end
    for (int i = 0; i < EP_N; i++)
      n.loss[i] = n.miss[i] == MISS_LOSS;
    irqpad[EP_N-1:0] = ep_irq;
    for (int w = 0; w < IRQ_WORDS; w++)
      n.summ[w] = |irqpad[w*32 +: 32];
    n.irq = s.irq_en && (|ep_irq);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.st <= S_IDLE;
      s.div <= TW'(DIV_RST);
    end
    else
      s <= n;
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign loss_vec = s.loss;
  assign irq = s.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_off_idle;
    !s.ctrl_en |=> s.st == S_IDLE && s.act == '0;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("sweep not aborted");

  property p_no_count;
    !s.ctrl_en |=> s.tmr == '0 && s.divc == '0;
  endproperty
  a_no_count: assert property (p_no_count) else $error("timers count while off");

  property p_adv;
    s.ctrl_en && s.st == S_SWEEP && !stall && s.idx != 8'(EP_N - 1)
      |=> s.idx == $past(s.idx) + 8'h01;
  endproperty
  a_adv: assert property (p_adv) else $error("sweep did not advance");

  property p_stall;
    s.ctrl_en && s.st == S_SWEEP && stall |=> $stable(s.idx);
  endproperty
  a_stall: assert property (p_stall) else $error("sweep moved on stall");

  property p_done;
    s.ctrl_en && s.st == S_SWEEP && !stall && s.idx == 8'(EP_N - 1)
      |=> s.done && s.st == S_IDLE;
  endproperty
  a_done: assert property (p_done) else $error("sweep end missed");

  property p_begin;
    s.ctrl_en && s.st == S_IDLE && s.pend != '0 |=> s.begun && s.st == S_SWEEP;
  endproperty
  a_begin: assert property (p_begin) else $error("sweep did not start");

  property p_ovr;
    s.ctrl_en && |(expd & (s.pend | s.act)) |=> s.ovr;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not flagged");

  property p_irq;
    ##1 irq == ($past(s.irq_en) && $past(|ep_irq));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_summ;
    ##1 s.summ[0] == $past(|ep_irq[31:0]);
  endproperty
  a_summ: assert property (p_summ) else $error("summary mismatch");

  property p_reload;
    s.ctrl_en && expd[0] |=> s.tmr[0] == '0;
  endproperty
  a_reload: assert property (p_reload) else $error("timer not reloaded");
endmodule : csc_top
`default_nettype wire

// file: verif/testbench.sv
// testbench: self-checking bench for csc_top, apb master and frame strobes.
// assumes: csc_pkg register map, pready one cycle after setup, 250 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import csc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic frame_lookup = 1'b0;
  logic frame_ccm_ok = 1'b0;
  logic [7:0] frame_ep_idx = 8'h00;
  logic [EP_N-1:0] ep_irq = '0;
  logic [EP_N-1:0] loss_vec;
  logic irq;
  logic [31:0] rd;
  logic er;
  logic [EP_N-1:0] exp_loss;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  csc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_lookup(frame_lookup), .frame_ccm_ok(frame_ccm_ok),
    .frame_ep_idx(frame_ep_idx), .ep_irq(ep_irq), .loss_vec(loss_vec), .irq(irq));
  always #2 pclk = ~pclk;
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("unexpected at %0t: run too long", $time);
      wrap_up();
    end
  end
  task chk(input logic [EP_N-1:0] got, input logic [EP_N-1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask : rd_chk
  task idle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : idle
  task wait_done;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, A_STAT, 32'h00000000);
      n++;
    end
    while (rd[STAT_DONE_B] !== 1'b1 && n < 300);
    chk(rd[STAT_DONE_B], 1'b1);
    apb(1'b1, A_STAT, 32'h00070000);
  endtask : wait_done
  task lookup(input logic [7:0] idx, input logic ok);
    @(posedge pclk);
    frame_lookup <= 1'b1;
    frame_ccm_ok <= ok;
    frame_ep_idx <= idx;
    @(posedge pclk);
    frame_lookup <= 1'b0;
    frame_ccm_ok <= 1'b0;
  endtask : lookup
  task t_reset;
    rd_chk(A_DIV, 32'h00000100);
    rd_chk(A_CTRL, 32'h00000000);
    apb(1'b0, 8'h30, 32'h00000000);
    chk(er, 1'b1);
  endtask : t_reset
  task t_extract;
    apb(1'b1, A_EPSEL, 32'h00000001);
    apb(1'b1, A_EPCFG, 32'h00011F07);
    apb(1'b1, A_XCFG, 32'h00000030);
    apb(1'b1, A_CTRL, 32'h00000001);
    apb(1'b1, A_FORCE, 32'h00000080);
    wait_done();
    rd_chk(A_EPSTAT, 32'h00001C00);
    lookup(8'h01, 1'b0);
    rd_chk(A_EPSTAT, 32'h00000000);
    apb(1'b1, A_FORCE, 32'h00000100);
    wait_done();
    rd_chk(A_EPSTAT, 32'h00000300);
    lookup(8'h01, 1'b0);
    apb(1'b1, A_XCFG, 32'h00000033);
    apb(1'b1, A_FORCE, 32'h00000180);
    wait_done();
    rd_chk(A_EPSTAT, 32'h00000000);
  endtask : t_extract
  task t_miss;
    apb(1'b1, A_EPSEL, 32'h00000000);
    repeat (6)
    begin
      apb(1'b1, A_FORCE, 32'h00000001);
      wait_done();
    end
    idle(1);
    chk(loss_vec, '0);
    apb(1'b1, A_FORCE, 32'h00000001);
    wait_done();
    idle(1);
    exp_loss = '1;
    exp_loss[1] = 1'b0;
    chk(loss_vec, exp_loss);
    rd_chk(A_EPSTAT, 32'h00000017);
    lookup(8'h05, 1'b1);
    idle(1);
    exp_loss[5] = 1'b0;
    chk(loss_vec, exp_loss);
  endtask : t_miss
  task t_stall;
    apb(1'b1, A_FORCE, 32'h00000001);
    idle(190);
    apb(1'b0, A_STAT, 32'h00000000);
    chk(rd[18:0], 19'h10001);
    idle(20);
    apb(1'b0, A_STAT, 32'h00000000);
    chk(rd[18:0], 19'h30000);
    apb(1'b1, A_STAT, 32'h00070000);
    apb(1'b1, A_FORCE, 32'h00000001);
    frame_ep_idx <= 8'hFF;
    frame_lookup <= 1'b1;
    repeat (100) @(posedge pclk);
    frame_lookup <= 1'b0;
    idle(95);
    apb(1'b0, A_STAT, 32'h00000000);
    chk(rd[STAT_DONE_B], 1'b0);
    wait_done();
  endtask : t_stall
  task t_disable;
    apb(1'b1, A_FORCE, 32'h00000001);
    idle(50);
    apb(1'b1, A_CTRL, 32'h00000000);
    apb(1'b0, A_STAT, 32'h00000000);
    chk(rd[8:0], 9'h000);
    rd_chk(A_EPSTAT, 32'h00000017);
    chk(loss_vec[0], 1'b1);
  endtask : t_disable
  task t_timer;
    realtime t0;
    int dt;
    apb(1'b1, A_DIV, 32'h0000000A);
    apb(1'b1, 8'h40, 32'h0000001E);
    apb(1'b1, A_STAT, 32'h00070000);
    idle(400);
    apb(1'b0, A_STAT, 32'h00000000);
    chk(rd[STAT_BEGUN_B], 1'b0);
    apb(1'b1, A_CTRL, 32'h00000001);
    t0 = $realtime;
    do
      apb(1'b0, A_STAT, 32'h00000000);
    while (rd[STAT_BEGUN_B] !== 1'b1 && $realtime - t0 < 2000.0);
    dt = int'(($realtime - t0) / 4.0);
    chk(dt >= 298 && dt <= 312, 1'b1);
    apb(1'b1, A_CTRL, 32'h00000000);
    apb(1'b1, 8'h40, 32'h00000002);
    apb(1'b1, A_STAT, 32'h00070000);
    apb(1'b1, A_CTRL, 32'h00000001);
    idle(300);
    apb(1'b0, A_STAT, 32'h00000000);
    chk(rd[STAT_OVR_B], 1'b1);
    apb(1'b1, A_CTRL, 32'h00000000);
    apb(1'b1, 8'h40, 32'h00000000);
    apb(1'b1, A_XPER, 32'h00000005);
    apb(1'b1, A_STAT, 32'h00070000);
    apb(1'b1, A_CTRL, 32'h00000001);
    idle(70);
    apb(1'b0, A_STAT, 32'h00000000);
    chk(rd[16:0], 17'h10080);
    apb(1'b1, A_CTRL, 32'h00000000);
  endtask : t_timer
  task t_irq;
    ep_irq[40] <= 1'b1;
    idle(3);
    chk(irq, 1'b0);
    apb(1'b1, A_CTRL, 32'h00000002);
    idle(2);
    chk(irq, 1'b1);
    rd_chk(A_SUMM, 32'h00000002);
    rd_chk(A_IRQ, 32'h00000001);
    ep_irq[40] <= 1'b0;
    idle(3);
    chk(irq, 1'b0);
  endtask : t_irq
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_extract();
    t_miss();
    t_stall();
    t_disable();
    t_timer();
    t_irq();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
